// ===== uesf_pkg.sv
// shared constants for the usb endpoint status and selection block
package uesf_pkg;
    localparam int UESF_NUM_EP = 5;
    // special-function register offsets
    localparam logic [7:0] UESF_NAKF_ADDR = 8'he9;
    localparam logic [7:0] UESF_VSIZE_ADDR = 8'hea;
    localparam logic [7:0] UESF_ECTRL_ADDR = 8'heb;
    localparam logic [7:0] UESF_STAT_ADDR = 8'hed;
    localparam logic [7:0] UESF_SEL_ADDR = 8'hef;
    // reset values
    localparam logic [7:0] UESF_NAKF_RST = 8'h00;
    localparam logic [7:0] UESF_STAT_RST = 8'h00;
    localparam logic [7:0] UESF_SEL_RST = 8'h00;
    // ep0 status field positions
    localparam int UESF_STAT_TOG_BIT = 3;
    localparam int UESF_STAT_SETUP_BIT = 2;
    localparam int UESF_STAT_IN_BIT = 1;
    localparam int UESF_STAT_OUT_BIT = 0;
    // endpoint select field positions
    localparam int UESF_SEL_DIR_BIT = 7;
    localparam int UESF_SEL_EP_LSB = 0;
    localparam int UESF_SEL_EP_MSB = 2;
    localparam logic UESF_DIR_IN = 1'b0;
    localparam logic UESF_DIR_OUT = 1'b1;
    // token kinds from the protocol engine
    typedef enum logic [2:0] {
        UESF_TOK_SETUP = 3'b001,
        UESF_TOK_IN = 3'b010,
        UESF_TOK_OUT = 3'b100
    } uesf_tok_e;
endpackage : uesf_pkg

// ===== uesf_status.sv
// usb endpoint nak flags, ep0 token status and endpoint/direction selection
// Summary of operation
// - one in-nak flag per in endpoint 0..4, set when an in request was naked
// - in fifo not ready until firmware writes its valid-size register
// - every in request to a not-ready in endpoint is answered with nak
// - a nak flag stays set until firmware writes zero to its bit
// - with fifos paired only the odd-numbered fifo's nak flag is active
// - ep0 status bit 3 read-only, toggle of last received data packet
// - ep0 status bit 2 set by setup token, cleared only by software or reset
// - ep0 status bit 1 read-only, set by in token, cleared by setup or out
// - ep0 status bit 0 read-only, set by out token, cleared by setup or in
// - engine disable then enable clears the toggle, in and out status bits
// - all endpoints share one fifo window and one control/size address set
// - select register: direction in bit 7, endpoint number in bits 2..0
// - selection also steers the shared endpoint control register access
// - direction 0 selects in fifo, 1 out fifo; endpoint field 0..4
module uesf_status
    import uesf_pkg::*;
#(
    parameter int NUM_EP = UESF_NUM_EP
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic tok_valid_i,
    input wire logic [2:0] tok_kind_i,
    input wire logic [2:0] tok_ep_i,
    input wire logic rx_pkt_valid_i,
    input wire logic [2:0] rx_pkt_ep_i,
    input wire logic rx_toggle_i,
    input wire logic [NUM_EP-1:0] in_sent_i,
    input wire logic [1:0] pair_en_i,
    input wire logic usb_engine_enable_i,
    input wire logic fifo_acc_i,
    output logic in_nak_o,
    output logic [NUM_EP-1:0] in_ready_o,
    output logic [NUM_EP-1:0] in_nak_flags_o,
    output logic [2:0] sel_endpoint_index_o,
    output logic sel_dir_out_o,
    output logic [NUM_EP-1:0] fifo_in_sel_o,
    output logic [NUM_EP-1:0] fifo_out_sel_o,
    output logic [NUM_EP-1:0] ep_ctrl_in_wr_o,
    output logic [NUM_EP-1:0] ep_ctrl_out_wr_o,
    output logic [7:0] sfr_wdata_fwd_o
);

    logic [NUM_EP-1:0] nakf_r;
    logic [NUM_EP-1:0] ready_r;
    logic [NUM_EP-1:0] pair_mask;
    logic [NUM_EP-1:0] nak_hit;
    logic [3:0] stat_vec;
    logic setup_r;
    logic tog_r;
    logic in_tok_r;
    logic out_tok_r;
    logic sel_dir_r;
    logic [2:0] sel_ep_r;
    logic wr_nakf, wr_vsize, wr_ectrl, wr_stat, wr_sel;
    logic tok_ep0;
    logic [7:0] rdata_nxt;

    // one-hot of an endpoint number; out of range gives zero
    function automatic logic [NUM_EP-1:0] ep_onehot(input logic [2:0] ep);
        logic [NUM_EP-1:0] oh;
        oh = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            if (ep == 3'(i)) begin
                oh[i] = 1'b1;
            end
        end
        return oh;
    endfunction : ep_onehot

    always_comb begin
        wr_nakf = 1'b0;
        wr_vsize = 1'b0;
        wr_ectrl = 1'b0;
        wr_stat = 1'b0;
        wr_sel = 1'b0;
        if (sfr_addr_i == UESF_NAKF_ADDR) begin
            wr_nakf = sfr_wr_i;
        end else if (sfr_addr_i == UESF_VSIZE_ADDR) begin
            wr_vsize = sfr_wr_i;
        end else if (sfr_addr_i == UESF_ECTRL_ADDR) begin
            wr_ectrl = sfr_wr_i;
        end else if (sfr_addr_i == UESF_STAT_ADDR) begin
            wr_stat = sfr_wr_i;
        end else if (sfr_addr_i == UESF_SEL_ADDR) begin
            wr_sel = sfr_wr_i;
        end
    end

    // even member of an enabled pair (1/2, 3/4) keeps its flag dead
    always_comb begin
        pair_mask = '0;
        if (NUM_EP > 2) begin
            pair_mask[2] = pair_en_i[0];
        end
        if (NUM_EP > 4) begin
            pair_mask[4] = pair_en_i[1];
        end
    end

    // endpoint select register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sel_dir_r <= UESF_SEL_RST[UESF_SEL_DIR_BIT];
            sel_ep_r <= UESF_SEL_RST[UESF_SEL_EP_MSB:UESF_SEL_EP_LSB];
        end else if (wr_sel) begin
            sel_dir_r <= sfr_wdata_i[UESF_SEL_DIR_BIT];
            sel_ep_r <= sfr_wdata_i[UESF_SEL_EP_MSB:UESF_SEL_EP_LSB];
        end
    end

    assign sel_endpoint_index_o = sel_ep_r;
    assign sel_dir_out_o = sel_dir_r;
    // selection steers the shared window and the shared register addresses
    assign fifo_in_sel_o = (fifo_acc_i && sel_dir_r == UESF_DIR_IN) ? ep_onehot(sel_ep_r) : '0;
    assign fifo_out_sel_o = (fifo_acc_i && sel_dir_r == UESF_DIR_OUT) ? ep_onehot(sel_ep_r) : '0;
    assign ep_ctrl_in_wr_o = (wr_ectrl && sel_dir_r == UESF_DIR_IN) ? ep_onehot(sel_ep_r) : '0;
    assign ep_ctrl_out_wr_o = (wr_ectrl && sel_dir_r == UESF_DIR_OUT) ? ep_onehot(sel_ep_r) : '0;
    assign sfr_wdata_fwd_o = sfr_wdata_i;

    // in fifo ready: a valid-size write arms it, a finished send disarms it
    generate
        for (genvar g = 0; g < NUM_EP; g++) begin : g_ready
            logic arm;
            assign arm = wr_vsize && sel_dir_r == UESF_DIR_IN && sel_ep_r == 3'(g);
            always_ff @(posedge ref_clk_i) begin
                if (!rst_b_i || !usb_engine_enable_i) begin
                    ready_r[g] <= 1'b0;
                end else if (arm) begin
                    ready_r[g] <= 1'b1;
                end else if (in_sent_i[g]) begin
                    ready_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign in_ready_o = ready_r;

    // nak answer is combinational so the engine can reply in the same cycle
    assign nak_hit = (tok_valid_i && tok_kind_i == UESF_TOK_IN) ? (ep_onehot(tok_ep_i) & ~ready_r) : '0;
    assign in_nak_o = |nak_hit;

    // set wins over a firmware clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            nakf_r <= UESF_NAKF_RST[NUM_EP-1:0];
        end else begin
            nakf_r <= ((wr_nakf ? (nakf_r & sfr_wdata_i[NUM_EP-1:0]) : nakf_r) | nak_hit) & ~pair_mask;
        end
    end

    assign in_nak_flags_o = nakf_r;

    assign tok_ep0 = tok_valid_i && tok_ep_i == 3'd0;

    // ep0 setup detect; a setup token beats a same-cycle software clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            setup_r <= UESF_STAT_RST[UESF_STAT_SETUP_BIT];
        end else if (tok_ep0 && tok_kind_i == UESF_TOK_SETUP) begin
            setup_r <= 1'b1;
        end else if (wr_stat && !sfr_wdata_i[UESF_STAT_SETUP_BIT]) begin
            setup_r <= 1'b0;
        end
    end

    // disabled engine holds toggle, in and out at zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || !usb_engine_enable_i) begin
            tog_r <= UESF_STAT_RST[UESF_STAT_TOG_BIT];
            in_tok_r <= UESF_STAT_RST[UESF_STAT_IN_BIT];
            out_tok_r <= UESF_STAT_RST[UESF_STAT_OUT_BIT];
        end else begin
            if (rx_pkt_valid_i && rx_pkt_ep_i == 3'd0) begin
                tog_r <= rx_toggle_i;
            end
            if (tok_ep0) begin
                in_tok_r <= (tok_kind_i == UESF_TOK_IN);
                out_tok_r <= (tok_kind_i == UESF_TOK_OUT);
            end
        end
    end

    // separate bits keep one writer per register
    always_comb begin
        stat_vec = 4'h0;
        stat_vec[UESF_STAT_TOG_BIT] = tog_r;
        stat_vec[UESF_STAT_SETUP_BIT] = setup_r;
        stat_vec[UESF_STAT_IN_BIT] = in_tok_r;
        stat_vec[UESF_STAT_OUT_BIT] = out_tok_r;
    end

    // read mux; reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_addr_i == UESF_NAKF_ADDR) begin
            rdata_nxt[NUM_EP-1:0] = nakf_r;
        end else if (sfr_addr_i == UESF_STAT_ADDR) begin
            rdata_nxt[3:0] = stat_vec;
        end else if (sfr_addr_i == UESF_SEL_ADDR) begin
            rdata_nxt[UESF_SEL_DIR_BIT] = sel_dir_r;
            rdata_nxt[UESF_SEL_EP_MSB:UESF_SEL_EP_LSB] = sel_ep_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rdata_nxt;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // nak flags and fifo readiness
    a_nak_sets_flag: assert property (
        nak_hit[1] && !pair_mask[1] |=> nakf_r[1])
        else $error("nak on ep1 did not set its flag");
    a_vsize_arms: assert property (
        wr_vsize && sel_dir_r == UESF_DIR_IN && sel_ep_r == 3'd0 && usb_engine_enable_i |=> ready_r[0])
        else $error("valid-size write did not arm ep0");
    a_sent_disarms: assert property (
        in_sent_i[1] && !wr_vsize |=> !ready_r[1])
        else $error("finished send did not disarm ep1");
    a_off_unarms: assert property (
        !usb_engine_enable_i |=> ready_r == '0)
        else $error("fifo ready while engine disabled");
    a_nak_when_unready: assert property (
        tok_valid_i && tok_kind_i == UESF_TOK_IN && tok_ep_i == 3'd3 && !ready_r[3] |-> in_nak_o)
        else $error("in to unready ep3 not naked");
    a_ready_no_nak: assert property (
        tok_valid_i && tok_kind_i == UESF_TOK_IN && tok_ep_i == 3'd1 && ready_r[1] |-> !in_nak_o)
        else $error("in to ready ep1 naked");
    a_flag_sticky: assert property (
        nakf_r[0] && !wr_nakf && !pair_mask[0] |=> nakf_r[0])
        else $error("nak flag cleared by itself");
    a_set_beats_clear: assert property (
        wr_nakf && nak_hit[2] && !pair_mask[2] |=> nakf_r[2])
        else $error("clear write beat a new nak");
    a_flag_write_clears: assert property (
        wr_nakf && !sfr_wdata_i[0] && !nak_hit[0] |=> !nakf_r[0])
        else $error("zero write did not clear ep0 flag");
    a_pair_even_dead: assert property (
        pair_en_i[0] |=> !nakf_r[2] || !$past(pair_en_i[0]))
        else $error("even flag of pair active");

    // ep0 token status
    a_toggle_tracks: assert property (
        rx_pkt_valid_i && rx_pkt_ep_i == 3'd0 && usb_engine_enable_i |=> tog_r == $past(rx_toggle_i))
        else $error("received toggle not captured");
    a_setup_sets: assert property (
        tok_ep0 && tok_kind_i == UESF_TOK_SETUP |=> setup_r)
        else $error("setup token not recorded");
    a_setup_holds: assert property (
        setup_r && !wr_stat |=> setup_r)
        else $error("setup bit cleared by token");
    a_in_token: assert property (
        tok_ep0 && tok_kind_i == UESF_TOK_IN && usb_engine_enable_i |=> in_tok_r && !out_tok_r)
        else $error("in token status wrong");
    a_out_token: assert property (
        tok_ep0 && tok_kind_i == UESF_TOK_OUT && usb_engine_enable_i |=> out_tok_r && !in_tok_r)
        else $error("out token status wrong");
    a_setup_clears_io: assert property (
        tok_ep0 && tok_kind_i == UESF_TOK_SETUP && usb_engine_enable_i |=> !in_tok_r && !out_tok_r)
        else $error("setup token left in or out set");
    a_disable_clears: assert property (
        !usb_engine_enable_i ##1 !usb_engine_enable_i |-> !tog_r && !in_tok_r && !out_tok_r)
        else $error("status not cleared while disabled");

    // selection and register readback
    a_fifo_in_route: assert property (
        fifo_acc_i && sel_dir_r == UESF_DIR_IN && sel_ep_r < 3'd5
        |-> $onehot(fifo_in_sel_o) && ((fifo_in_sel_o >> sel_ep_r) == NUM_EP'(1)) && fifo_out_sel_o == '0)
        else $error("in fifo window misrouted");
    a_fifo_idle: assert property (
        !fifo_acc_i |-> fifo_in_sel_o == '0 && fifo_out_sel_o == '0)
        else $error("fifo selected without an access");
    a_ctrl_routing: assert property (
        wr_ectrl |-> $onehot0(ep_ctrl_in_wr_o | ep_ctrl_out_wr_o)
        && ((ep_ctrl_out_wr_o != '0) == (sel_dir_r && sel_ep_r < 3'd5)))
        else $error("control access misrouted");
    a_sel_reads_back: assert property (
        sfr_rd_i && sfr_addr_i == UESF_SEL_ADDR |=> sfr_rdata_o[6:3] == 4'h0
        && sfr_rdata_o[2:0] == $past(sel_ep_r) && sfr_rdata_o[7] == $past(sel_dir_r))
        else $error("select register readback wrong");
    a_nakf_rsvd_zero: assert property (
        sfr_rd_i && sfr_addr_i == UESF_NAKF_ADDR |=> sfr_rdata_o[7:NUM_EP] == '0)
        else $error("reserved nak flag bits not zero");
    a_stat_rsvd_zero: assert property (
        sfr_rd_i && sfr_addr_i == UESF_STAT_ADDR |=> sfr_rdata_o[7:4] == 4'h0)
        else $error("reserved status bits not zero");

    c_nak_flag: cover property (nak_hit != '0 ##1 nakf_r != '0);
    c_setup_then_in: cover property (tok_ep0 && tok_kind_i == UESF_TOK_SETUP ##[1:8]
        tok_ep0 && tok_kind_i == UESF_TOK_IN);
    c_set_beats_clear: cover property (wr_nakf && nak_hit != '0);
    c_out_fifo_sel: cover property (fifo_out_sel_o[4]);
    c_engine_cycle: cover property (!usb_engine_enable_i ##1 usb_engine_enable_i);

endmodule : uesf_status

// ===== uesf_host_model.sv
// usb host model issuing tokens and data packets towards the status block
module uesf_host_model
    import uesf_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic in_nak_i,
    output logic tok_valid_o,
    output logic [2:0] tok_kind_o,
    output logic [2:0] tok_ep_o,
    output logic rx_pkt_valid_o,
    output logic [2:0] rx_pkt_ep_o,
    output logic rx_toggle_o,
    output logic [UESF_NUM_EP-1:0] in_sent_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {tok_valid_o, tok_kind_o, tok_ep_o, rx_pkt_valid_o, rx_pkt_ep_o, rx_toggle_o, in_sent_o} = '0;
    end
    // released fields show the inverse so a stale value is never trusted
    task automatic token(input uesf_tok_e k, input logic [2:0] ep, output logic nak);
        @(negedge ref_clk_i);
        tok_valid_o = 1'b1;
        tok_kind_o = k;
        tok_ep_o = ep;
        #1 nak = in_nak_i;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        tok_valid_o = 1'b0;
        tok_kind_o = ~k;
        tok_ep_o = ~ep;
    endtask : token
    task automatic data(input logic [2:0] ep, input logic tog);
        @(negedge ref_clk_i);
        rx_pkt_valid_o = 1'b1;
        rx_pkt_ep_o = ep;
        rx_toggle_o = tog;
        @(negedge ref_clk_i);
        rx_pkt_valid_o = 1'b0;
        rx_pkt_ep_o = ~ep;
        rx_toggle_o = ~tog;
    endtask : data
    task automatic sent(input int ep);
        @(negedge ref_clk_i);
        in_sent_o[ep] = 1'b1;
        @(negedge ref_clk_i);
        in_sent_o = '0;
    endtask : sent
endmodule : uesf_host_model

// ===== usb_endpoint_status_flags_tb.sv
// self-checking bench for the endpoint status and selection block
module usb_endpoint_status_flags_tb
    import uesf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i, rst_b_i, sfr_wr_i, sfr_rd_i, tok_valid_i, rx_pkt_valid_i, rx_toggle_i;
    logic usb_engine_enable_i, fifo_acc_i, in_nak_o, sel_dir_out_o;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, sfr_wdata_fwd_o, stat_e, d;
    logic [2:0] tok_kind_i, tok_ep_i, rx_pkt_ep_i, sel_endpoint_index_o, ep;
    logic [1:0] pair_en_i;
    logic [4:0] in_sent_i, in_ready_o, in_nak_flags_o, fifo_in_sel_o, fifo_out_sel_o, oh;
    logic [4:0] ep_ctrl_in_wr_o, ep_ctrl_out_wr_o;
    logic dir, nak_v;
    uesf_tok_e tk;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    uesf_tok_e kinds[3] = '{UESF_TOK_SETUP, UESF_TOK_IN, UESF_TOK_OUT};
    uesf_status DUT (.ref_clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
        .tok_valid_i, .tok_kind_i, .tok_ep_i, .rx_pkt_valid_i, .rx_pkt_ep_i, .rx_toggle_i, .in_sent_i,
        .pair_en_i, .usb_engine_enable_i, .fifo_acc_i, .in_nak_o, .in_ready_o, .in_nak_flags_o,
        .sel_endpoint_index_o, .sel_dir_out_o, .fifo_in_sel_o, .fifo_out_sel_o, .ep_ctrl_in_wr_o,
        .ep_ctrl_out_wr_o, .sfr_wdata_fwd_o);
    uesf_host_model host (.ref_clk_i, .in_nak_i(in_nak_o), .tok_valid_o(tok_valid_i),
        .tok_kind_o(tok_kind_i), .tok_ep_o(tok_ep_i), .rx_pkt_valid_o(rx_pkt_valid_i),
        .rx_pkt_ep_o(rx_pkt_ep_i), .rx_toggle_o(rx_toggle_i), .in_sent_o(in_sent_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        @(negedge ref_clk_i);
        sfr_wr_i = 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge ref_clk_i);
        sfr_rd_i = 1'b0;
        chk(sfr_rdata_o, exp);
    endtask : rchk
    function automatic logic [7:0] nxt_stat(input logic [7:0] s, input uesf_tok_e k);
        if (k == UESF_TOK_SETUP) s[2:0] = 3'b100;
        else if (k == UESF_TOK_IN) s[1:0] = 2'b10;
        else s[1:0] = 2'b01;
        return s;
    endfunction : nxt_stat
    task automatic tok(input uesf_tok_e k, input logic [2:0] e, input logic exp_nak);
        logic nak;
        host.token(k, e, nak);
        chk(8'(nak), 8'(exp_nak));
        if (e == 3'd0) stat_e = nxt_stat(stat_e, k);
    endtask : tok
    initial begin
        {rst_b_i, sfr_wr_i, sfr_rd_i, fifo_acc_i, pair_en_i, sfr_addr_i, sfr_wdata_i, stat_e} = '0;
        usb_engine_enable_i = 1'b1;
        void'($urandom(32'h3644));
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_b_i = 1'b1;
        rchk(UESF_STAT_ADDR, UESF_STAT_RST);
        rchk(UESF_SEL_ADDR, UESF_SEL_RST);
        rchk(UESF_NAKF_ADDR, UESF_NAKF_RST);
        rchk(8'hee, 8'h00);
        for (int i = 0; i < 8; i++) begin
            ep = 3'($urandom % 5);
            dir = 1'($urandom);
            oh = 5'b1 << ep;
            wr(UESF_SEL_ADDR, {dir, 4'($urandom), ep});
            rchk(UESF_SEL_ADDR, {dir, 4'h0, ep});
            @(negedge ref_clk_i);
            {fifo_acc_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {2'b11, UESF_ECTRL_ADDR, 8'($urandom)};
            #1 chk(fifo_in_sel_o, dir ? 5'h0 : oh);
            chk(fifo_out_sel_o, dir ? oh : 5'h0);
            chk(ep_ctrl_in_wr_o, dir ? 5'h0 : oh);
            chk(ep_ctrl_out_wr_o, dir ? oh : 5'h0);
            chk(sfr_wdata_fwd_o, sfr_wdata_i);
            chk({sel_dir_out_o, 4'h0, sel_endpoint_index_o}, {dir, 4'h0, ep});
            @(negedge ref_clk_i) {fifo_acc_i, sfr_wr_i} = 2'b00;
        end
        for (int e = 0; e < 5; e++) begin
            wr(UESF_SEL_ADDR, 8'(e));
            tok(UESF_TOK_IN, 3'(e), 1'b1);
            chk(in_nak_flags_o, 5'h1f >> (4 - e));
            wr(UESF_VSIZE_ADDR, 8'h40);
            chk(in_ready_o[e], 1'b1);
            tok(UESF_TOK_IN, 3'(e), 1'b0);
            host.sent(e);
        end
        wr(UESF_NAKF_ADDR, 8'hff);
        repeat (20) @(negedge ref_clk_i);
        rchk(UESF_NAKF_ADDR, 8'h1f);
        wr(UESF_NAKF_ADDR, 8'h15);
        rchk(UESF_NAKF_ADDR, 8'h15);
        wr(UESF_NAKF_ADDR, 8'h00);
        // a new nak and a clearing write in the same cycle: the nak wins
        fork
            host.token(UESF_TOK_IN, 3'd2, nak_v);
            wr(UESF_NAKF_ADDR, 8'h00);
        join
        chk(8'(nak_v), 8'h01);
        chk(in_nak_flags_o, 5'b00100);
        wr(UESF_NAKF_ADDR, 8'h00);
        pair_en_i = 2'b11;
        for (int e = 1; e < 6; e++) tok(UESF_TOK_IN, 3'(e), e < 5);
        chk(in_nak_flags_o, 5'b01010);
        pair_en_i = 2'b00;
        for (int i = 0; i < 14; i++) begin
            tk = kinds[$urandom % 3];
            tok(tk, 3'd0, tk == UESF_TOK_IN);
            if (i == 0 || 1'($urandom)) begin
                dir = 1'($urandom);
                host.data(3'd0, dir);
                stat_e[3] = dir;
            end
            rchk(UESF_STAT_ADDR, stat_e);
        end
        tok(UESF_TOK_SETUP, 3'd0, 1'b0);
        tok(UESF_TOK_OUT, 3'd0, 1'b0);
        wr(UESF_STAT_ADDR, 8'hff);
        rchk(UESF_STAT_ADDR, stat_e);
        wr(UESF_STAT_ADDR, 8'h00);
        stat_e[2] = 1'b0;
        rchk(UESF_STAT_ADDR, stat_e);
        tok(UESF_TOK_SETUP, 3'd0, 1'b0);
        host.data(3'd0, 1'b1);
        wr(UESF_VSIZE_ADDR, 8'h01);
        chk(in_ready_o, 5'h10);
        @(negedge ref_clk_i) usb_engine_enable_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        chk(in_ready_o, 5'h00);
        usb_engine_enable_i = 1'b1;
        rchk(UESF_STAT_ADDR, 8'h04);
        final_report();
    end
endmodule : usb_endpoint_status_flags_tb
